// >>> angr_pkg.sv
// Package: offsets, field positions, reset values and enums of the next-page and gig config bank
package angr_pkg;

   // Register offsets (5-bit management register address)
   localparam logic [4:0]  ANGR_OFS_ADV_BASE   = 5'h04;
   localparam logic [4:0]  ANGR_OFS_PARTNER_BS = 5'h05;
   localparam logic [4:0]  ANGR_OFS_EXPANSION  = 5'h06;
   localparam logic [4:0]  ANGR_OFS_TX_NP      = 5'h07;
   localparam logic [4:0]  ANGR_OFS_RX_NP      = 5'h08;
   localparam logic [4:0]  ANGR_OFS_GIG_CFG    = 5'h09;

   // Expansion register bit positions
   localparam int ANGR_EXP_PARTNER_AN  = 0;
   localparam int ANGR_EXP_PAGE_RX     = 1;
   localparam int ANGR_EXP_OWN_NP      = 2;
   localparam int ANGR_EXP_PARTNER_NP  = 3;
   localparam int ANGR_EXP_PD_FAULT    = 4;
   localparam int ANGR_EXP_LOC_SELECT  = 5;
   localparam int ANGR_EXP_LOC_VALID   = 6;

   // Next-page register bit positions
   localparam int ANGR_NP_MORE   = 15;
   localparam int ANGR_NP_ACK    = 14;
   localparam int ANGR_NP_MSG    = 13;
   localparam int ANGR_NP_ACK2   = 12;
   localparam int ANGR_NP_PARITY = 11;
   localparam int ANGR_NP_CODE_W = 11;

   // Configuration register bit positions
   localparam int ANGR_CFG_TEST_LSB  = 13;
   localparam int ANGR_CFG_ROLE_EN   = 12;
   localparam int ANGR_CFG_ROLE_VAL  = 11;
   localparam int ANGR_CFG_PORT_TYPE = 10;
   localparam int ANGR_CFG_ADV_FULL  = 9;
   localparam int ANGR_CFG_ADV_HALF  = 8;
   localparam int ANGR_CFG_AUTO_DIAG = 7;

   // Reset values
   localparam logic [15:0] ANGR_RST_EXPANSION = 16'h0064;
   localparam logic [15:0] ANGR_RST_TX_NP     = 16'h2001;
   localparam logic [15:0] ANGR_RST_RX_NP     = 16'h2001;
   localparam logic [15:0] ANGR_RST_GIG_CFG   = 16'h0300;
   localparam logic [10:0] ANGR_RST_NP_CODE   = 11'h001;

   // Write masks: writable bits of the transmit next-page and configuration registers
   localparam logic [15:0] ANGR_WMASK_TX_NP   = 16'hb7ff;
   localparam logic [15:0] ANGR_WMASK_GIG_CFG = 16'hff80;

   // Transmit test modes
   typedef enum logic [2:0] {
      ANGR_TM_NORMAL    = 3'h0,
      ANGR_TM_WAVEFORM  = 3'h1,
      ANGR_TM_JIT_MSTR  = 3'h2,
      ANGR_TM_JIT_SLV   = 3'h3,
      ANGR_TM_DISTORT   = 3'h4,
      ANGR_TM_SCR_IDLE  = 3'h5,
      ANGR_TM_REP_0001  = 3'h6,
      ANGR_TM_PULSE_63Z = 3'h7
   } angr_test_mode_t;

   // Cable diagnostic launcher states
   typedef enum logic [2:0] {
      ANGR_DG_IDLE = 3'b001,
      ANGR_DG_ARM  = 3'b010,
      ANGR_DG_FIRE = 3'b100
   } angr_diag_state_t;

endpackage : angr_pkg

// >>> angr_sync.sv
// Two-flop synchroniser bank for asynchronous status inputs
`timescale 1ns/1ps
module angr_sync
   import angr_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             rst_b_in,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage1_nxt;
   logic [WIDTH-1:0] stage2_r;
   logic [WIDTH-1:0] stage2_nxt;

   // Next values: first stage only feeds second
   always_comb
   begin
      stage1_nxt = async_in;
      stage2_nxt = stage1_r;
   end

   // Register both stages
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         stage1_r <= '0;
         stage2_r <= '0;
      end
      else
      begin
         stage1_r <= stage1_nxt;
         stage2_r <= stage2_nxt;
      end
   end

   assign sync_out = stage2_r;

endmodule : angr_sync

// >>> angr_regs.sv
// Next-page, expansion and gigabit configuration management register bank
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Parallel-detect fault latches high, clears on read
// - Page-received latches high, clears on read
// - Storage location bits 6 and 5 read one
// - Bit 3 shows partner next-page ability
// - Bit 2 shows own next-page ability, reset one
// - Bit 0 shows partner negotiation ability
// - Tx bit 15 requests more pages
// - Tx bit 13 selects message page, reset one
// - Tx bit 12 sets outgoing acknowledge two
// - Tx parity flips per sent page, starts inverted
// - Tx bits 10-0 hold code, reset 0x1
// - Rx page flags captured from latest page
// - Rx parity flips per received page
// - Rx bits 10-0 hold partner code
// - Bits 15-13 select transmit test mode
// - Bit 12 forces role from bit 11
// - Bit 10 declares multi-port device
// - Bits 9,8 advertise gig full, half
// - Bit 7 launches cable diagnostic after link down
module angr_regs
   import angr_pkg::*;
(
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_b_in,
   // Management register access (address, write and read strobes)
   input  wire logic [4:0]  reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [15:0] reg_wdata_in,
   output logic      [15:0] reg_rdata_out,
   // Strap defaults for gigabit advertisement, sampled after reset
   input  wire logic        strap_adv_gig_full_in,
   input  wire logic        strap_adv_gig_half_in,
   // Negotiation engine events and status (same clock)
   input  wire logic        parallel_detect_fault_in,
   input  wire logic        page_received_in,
   input  wire logic        page_sent_in,
   input  wire logic        partner_np_capable_in,
   input  wire logic        partner_negotiation_capable_in,
   input  wire logic        own_base_parity_in,
   input  wire logic        partner_base_parity_in,
   input  wire logic        base_page_done_in,
   input  wire logic [15:0] rx_page_word_in,
   // Line status from the analog side (asynchronous)
   input  wire logic        link_up_in,
   // Controls to the PHY core
   output logic             tx_more_pages_out,
   output logic             tx_msg_page_out,
   output logic             tx_ack_two_out,
   output logic             tx_page_parity_out,
   output logic [10:0]      tx_page_code_out,
   output logic [2:0]       test_mode_out,
   output logic             manual_role_enable_out,
   output logic             manual_role_value_out,
   output logic             port_multi_out,
   output logic             adv_gig_full_out,
   output logic             adv_gig_half_out,
   output logic             cable_diag_start_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised link status
   logic link_up_s;

   angr_sync #(.WIDTH(1)) u_link_sync (
      .clock_in (clock_in),
      .rst_b_in (rst_b_in),
      .async_in (link_up_in),
      .sync_out (link_up_s)
   );

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic             pd_fault_r;
   logic             pd_fault_nxt;
   logic             page_rx_r;
   logic             page_rx_nxt;
   logic [15:0]      tx_np_r;
   logic [15:0]      tx_np_nxt;
   logic [15:0]      rx_np_r;
   logic [15:0]      rx_np_nxt;
   logic [15:0]      cfg_r;
   logic [15:0]      cfg_nxt;
   logic             strap_done_r;
   logic             strap_done_nxt;
   logic             link_prev_r;
   logic             link_prev_nxt;
   logic             diag_pulse_r;
   logic             diag_pulse_nxt;
   logic [15:0]      rdata_r;
   logic [15:0]      rdata_nxt;
   angr_diag_state_t dg_r;
   angr_diag_state_t dg_nxt;
   logic             rd_exp;
   logic             wr_tx;
   logic             wr_cfg;
   logic [15:0]      exp_view;

   // Decode of strobes
   assign rd_exp = reg_rd_in && (reg_addr_in == ANGR_OFS_EXPANSION);
   assign wr_tx  = reg_wr_in && (reg_addr_in == ANGR_OFS_TX_NP);
   assign wr_cfg = reg_wr_in && (reg_addr_in == ANGR_OFS_GIG_CFG);

   // Assembled expansion register view
   always_comb
   begin
      exp_view                      = '0;
      exp_view[ANGR_EXP_LOC_VALID]  = 1'b1;
      exp_view[ANGR_EXP_LOC_SELECT] = 1'b1;
      exp_view[ANGR_EXP_PD_FAULT]   = pd_fault_r;
      exp_view[ANGR_EXP_PARTNER_NP] = partner_np_capable_in;
      exp_view[ANGR_EXP_OWN_NP]     = ANGR_RST_EXPANSION[ANGR_EXP_OWN_NP];
      exp_view[ANGR_EXP_PAGE_RX]    = page_rx_r;
      exp_view[ANGR_EXP_PARTNER_AN] = partner_negotiation_capable_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Latched-high status: event set wins over the clearing read
   always_comb
   begin
      pd_fault_nxt = pd_fault_r;
      page_rx_nxt  = page_rx_r;
      if (rd_exp)
      begin
         pd_fault_nxt = 1'b0;
         page_rx_nxt  = 1'b0;
      end
      if (parallel_detect_fault_in)
         pd_fault_nxt = 1'b1;
      if (page_received_in)
         page_rx_nxt = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit and received next-page registers
   always_comb
   begin
      tx_np_nxt = tx_np_r;
      rx_np_nxt = rx_np_r;
      if (wr_tx)
         tx_np_nxt = (reg_wdata_in & ANGR_WMASK_TX_NP)
                   | (tx_np_r & ~ANGR_WMASK_TX_NP);
      // Parity seeds from the base pages until next pages begin
      if (!base_page_done_in)
      begin
         tx_np_nxt[ANGR_NP_PARITY] = ~own_base_parity_in;
         rx_np_nxt[ANGR_NP_PARITY] = ~partner_base_parity_in;
      end
      else
      begin
         if (page_sent_in)
            tx_np_nxt[ANGR_NP_PARITY] = ~tx_np_r[ANGR_NP_PARITY];
         if (page_received_in)
         begin
            rx_np_nxt = rx_page_word_in;
            rx_np_nxt[ANGR_NP_PARITY] = ~rx_np_r[ANGR_NP_PARITY];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration register, strap defaults taken once after reset release
   always_comb
   begin
      cfg_nxt        = cfg_r;
      strap_done_nxt = 1'b1;
      if (!strap_done_r)
      begin
         cfg_nxt[ANGR_CFG_ADV_FULL] = strap_adv_gig_full_in;
         cfg_nxt[ANGR_CFG_ADV_HALF] = strap_adv_gig_half_in;
      end
      if (wr_cfg)
         cfg_nxt = (reg_wdata_in & ANGR_WMASK_GIG_CFG)
                 | (cfg_r & ~ANGR_WMASK_GIG_CFG);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cable diagnostic launcher: one pulse per link-down when enabled
   always_comb
   begin
      link_prev_nxt  = link_up_s;
      diag_pulse_nxt = 1'b0;
      dg_nxt         = dg_r;
      case (dg_r)
         ANGR_DG_IDLE:
         begin
            if (link_prev_r && !link_up_s)
               dg_nxt = ANGR_DG_ARM;
         end
         ANGR_DG_ARM:
         begin
            if (cfg_r[ANGR_CFG_AUTO_DIAG])
               dg_nxt = ANGR_DG_FIRE;
            else
               dg_nxt = ANGR_DG_IDLE;
         end
         ANGR_DG_FIRE:
         begin
            diag_pulse_nxt = 1'b1;
            dg_nxt         = ANGR_DG_IDLE;
         end
         default:
            dg_nxt = ANGR_DG_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered read data; unmapped offsets read zero
   always_comb
   begin
      rdata_nxt = rdata_r;
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            ANGR_OFS_EXPANSION: rdata_nxt = exp_view;
            ANGR_OFS_TX_NP:     rdata_nxt = tx_np_r;
            ANGR_OFS_RX_NP:     rdata_nxt = rx_np_r;
            ANGR_OFS_GIG_CFG:   rdata_nxt = cfg_r;
            default:            rdata_nxt = '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register latched status flags
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         pd_fault_r <= 1'b0;
         page_rx_r  <= 1'b0;
      end
      else
      begin
         pd_fault_r <= pd_fault_nxt;
         page_rx_r  <= page_rx_nxt;
      end
   end

   // Register transmit and received next pages
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         tx_np_r <= ANGR_RST_TX_NP;
         rx_np_r <= ANGR_RST_RX_NP;
      end
      else
      begin
         tx_np_r <= tx_np_nxt;
         rx_np_r <= rx_np_nxt;
      end
   end

   // Register configuration and strap capture flag
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         cfg_r        <= ANGR_RST_GIG_CFG;
         strap_done_r <= 1'b0;
      end
      else
      begin
         cfg_r        <= cfg_nxt;
         strap_done_r <= strap_done_nxt;
      end
   end

   // Register diagnostic launcher state
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         link_prev_r  <= 1'b0;
         diag_pulse_r <= 1'b0;
         dg_r         <= ANGR_DG_IDLE;
      end
      else
      begin
         link_prev_r  <= link_prev_nxt;
         diag_pulse_r <= diag_pulse_nxt;
         dg_r         <= dg_nxt;
      end
   end

   // Register read data
   always_ff @(posedge clock_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         rdata_r <= '0;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flip-flops
   assign reg_rdata_out          = rdata_r;
   assign tx_more_pages_out      = tx_np_r[ANGR_NP_MORE];
   assign tx_msg_page_out        = tx_np_r[ANGR_NP_MSG];
   assign tx_ack_two_out         = tx_np_r[ANGR_NP_ACK2];
   assign tx_page_parity_out     = tx_np_r[ANGR_NP_PARITY];
   assign tx_page_code_out       = tx_np_r[ANGR_NP_CODE_W-1:0];
   assign test_mode_out          = cfg_r[ANGR_CFG_TEST_LSB+2:ANGR_CFG_TEST_LSB];
   assign manual_role_enable_out = cfg_r[ANGR_CFG_ROLE_EN];
   assign manual_role_value_out  = cfg_r[ANGR_CFG_ROLE_VAL];
   assign port_multi_out         = cfg_r[ANGR_CFG_PORT_TYPE];
   assign adv_gig_full_out       = cfg_r[ANGR_CFG_ADV_FULL];
   assign adv_gig_half_out       = cfg_r[ANGR_CFG_ADV_HALF];
   assign cable_diag_start_out   = diag_pulse_r;

endmodule : angr_regs

// >>> angr_monitor.sv
// Checker: concurrent properties on the next-page and gig config bank ports
`timescale 1ns/1ps
module angr_monitor
(
   // Clock and reset
   input wire logic        clock_in,
   input wire logic        rst_b_in,
   // Register access
   input wire logic [4:0]  reg_addr_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [15:0] reg_wdata_in,
   input wire logic [15:0] reg_rdata_out,
   // Engine events and status
   input wire logic        parallel_detect_fault_in,
   input wire logic        page_received_in,
   input wire logic        page_sent_in,
   input wire logic        base_page_done_in,
   input wire logic        link_up_in,
   // Bank outputs
   input wire logic        tx_more_pages_out,
   input wire logic        tx_page_parity_out,
   input wire logic [10:0] tx_page_code_out,
   input wire logic [2:0]  test_mode_out,
   input wire logic        adv_gig_full_out,
   input wire logic        cable_diag_start_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   ////////////////////////////////////////////////////////////////////////////////
   // Access decodes and the combined latch event
   wire rd6 = reg_rd_in && (reg_addr_in == 5'h06);
   wire wr7 = reg_wr_in && (reg_addr_in == 5'h07);
   wire wr9 = reg_wr_in && (reg_addr_in == 5'h09);
   wire ev  = parallel_detect_fault_in || page_received_in;

   ////////////////////////////////////////////////////////////////////////////////
   // Properties
   exp_const_a: assert property (rd6 |=> reg_rdata_out[6:5] == 2'h3 && reg_rdata_out[2])
      else $error("expansion constant bits wrong");
   fault_latch_a: assert property ($past(parallel_detect_fault_in) && rd6 |=> reg_rdata_out[4])
      else $error("fault flag not latched");
   page_latch_a: assert property ($past(page_received_in) && rd6 |=> reg_rdata_out[1])
      else $error("page flag not latched");
   read_clear_a: assert property ((rd6 && !ev) ##1 (!rd6 && !ev) ##1 (rd6 && !ev)
      |=> !reg_rdata_out[4] && !reg_rdata_out[1])
      else $error("latched flags not cleared by read");
   coincide_a: assert property ((rd6 && page_received_in) ##1 !rd6 ##1 rd6 |=> reg_rdata_out[1])
      else $error("event during clearing read lost");
   cfg_write_a: assert property (wr9 |=> test_mode_out == $past(reg_wdata_in[15:13])
      && adv_gig_full_out == $past(reg_wdata_in[9]))
      else $error("config write not applied");
   txnp_write_a: assert property (wr7 |=> tx_page_code_out == $past(reg_wdata_in[10:0])
      && tx_more_pages_out == $past(reg_wdata_in[15]))
      else $error("next page write not applied");
   tx_toggle_a: assert property (page_sent_in && base_page_done_in
      |=> tx_page_parity_out != $past(tx_page_parity_out))
      else $error("tx parity did not invert");
   diag_pulse_a: assert property (cable_diag_start_out
      |-> ($past(link_up_in, 6) && !$past(link_up_in, 5)) ##1 !cable_diag_start_out)
      else $error("diagnostic pulse wrong");

   // Main scenarios reached
   cover property (cable_diag_start_out);
   cover property (rd6 && page_received_in);
   cover property (test_mode_out == 3'h7);
endmodule : angr_monitor

// >>> angr_engine_model.sv
// Negotiation engine stand-in driving the bank's event and status inputs
`timescale 1ns/1ps
module angr_engine_model
(
   // Clock
   input  wire logic   clock_in,
   // Events and status toward the bank
   output logic        pd_fault_out,
   output logic        page_rx_out,
   output logic        page_sent_out,
   output logic        np_cap_out,
   output logic        an_cap_out,
   output logic        done_out,
   output logic        link_out,
   output logic [15:0] word_out
);
   // Idle levels at time zero
   initial
   begin
      {pd_fault_out, page_rx_out, page_sent_out, np_cap_out, an_cap_out, done_out} = '0;
      link_out = 1'b1;
      word_out = 16'h0000;
   end

   // Status levels: partner abilities, base pages done, link
   task set_status(input logic np, input logic an, input logic dn, input logic lk);
      np_cap_out = np;
      an_cap_out = an;
      done_out = dn;
      link_out = lk;
   endtask : set_status

   // One-cycle event: 0 fault, 1 page in, 2 page out; the word is inverted after
   task pulse(input logic [1:0] kind, input logic [15:0] w);
      word_out = w;
      pd_fault_out = (kind == 2'h0);
      page_rx_out = (kind == 2'h1);
      page_sent_out = (kind == 2'h2);
      @(posedge clock_in);
      #1;
      {pd_fault_out, page_rx_out, page_sent_out} = '0;
      word_out = ~w;
   endtask : pulse
endmodule : angr_engine_model

// >>> angr_regs_tb_top.sv
// Testbench top: register access, engine events and diagnostic launch
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end
module angr_regs_tb_top;
   // Bench-driven access signals
   logic        clock_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic [4:0]  reg_addr_in = 5'h00;
   logic        reg_wr_in = 1'b0;
   logic        reg_rd_in = 1'b0;
   logic [15:0] reg_wdata_in = 16'h0000;
   logic [15:0] reg_rdata_out, rx_page_word_in, w;
   // Engine side and bank outputs
   logic        parallel_detect_fault_in, page_received_in, page_sent_in, link_up_in;
   logic        partner_np_capable_in, partner_negotiation_capable_in, base_page_done_in;
   logic        tx_more_pages_out, tx_msg_page_out, tx_ack_two_out, tx_page_parity_out;
   logic [10:0] tx_page_code_out;
   logic [2:0]  test_mode_out;
   logic        manual_role_enable_out, manual_role_value_out, port_multi_out;
   logic        adv_gig_full_out, adv_gig_half_out, cable_diag_start_out, hit;
   int          mismatches = 0;
   int          n_compared = 0;
   // Straps and base-page parities, all but the gig half strap changed by the scenarios
   logic        strap_adv_gig_full_in = 1'b1;
   logic        strap_adv_gig_half_in = 1'b1;
   logic        own_base_parity_in = 1'b1;
   logic        partner_base_parity_in = 1'b1;
   // Grouped output views for compact compares
   wire  [13:0] tx_view  = {tx_more_pages_out, tx_msg_page_out, tx_ack_two_out,
                            tx_page_code_out};
   wire  [7:0]  cfg_view = {test_mode_out, manual_role_enable_out, manual_role_value_out,
                            port_multi_out, adv_gig_full_out, adv_gig_half_out};

   always #20 clock_in = ~clock_in;

   angr_regs dut_u
   (
      .clock_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
      .reg_rdata_out, .strap_adv_gig_full_in, .strap_adv_gig_half_in,
      .parallel_detect_fault_in, .page_received_in, .page_sent_in, .partner_np_capable_in,
      .partner_negotiation_capable_in, .own_base_parity_in,
      .partner_base_parity_in, .base_page_done_in, .rx_page_word_in, .link_up_in,
      .tx_more_pages_out, .tx_msg_page_out, .tx_ack_two_out, .tx_page_parity_out,
      .tx_page_code_out, .test_mode_out, .manual_role_enable_out, .manual_role_value_out,
      .port_multi_out, .adv_gig_full_out, .adv_gig_half_out, .cable_diag_start_out
   );

   angr_engine_model eng_u
   (
      .clock_in(clock_in), .pd_fault_out(parallel_detect_fault_in),
      .page_rx_out(page_received_in), .page_sent_out(page_sent_in),
      .np_cap_out(partner_np_capable_in), .an_cap_out(partner_negotiation_capable_in),
      .done_out(base_page_done_in), .link_out(link_up_in), .word_out(rx_page_word_in)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Access tasks: strobe one cycle, then one idle cycle
   task wr_reg(input logic [4:0] a, input logic [15:0] v);
      reg_addr_in = a;
      reg_wdata_in = v;
      reg_wr_in = 1'b1;
      @(posedge clock_in);
      #1;
      reg_wr_in = 1'b0;
      @(posedge clock_in);
      #1;
   endtask : wr_reg

   task rd_chk(input logic [4:0] a, input logic [15:0] e);
      reg_addr_in = a;
      reg_rd_in = 1'b1;
      @(posedge clock_in);
      #1;
      reg_rd_in = 1'b0;
      `CHK(reg_rdata_out, e)
      @(posedge clock_in);
      #1;
   endtask : rd_chk

   // Looks for a launch pulse over a fixed span
   task watch_diag;
      hit = 1'b0;
      repeat (12)
      begin
         @(posedge clock_in);
         #1;
         hit = hit | cable_diag_start_out;
      end
   endtask : watch_diag

   task results;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : results

   // Watchdog, far beyond the roughly 150 cycles the tests need
   initial
   begin
      #50000;
      mismatches++;
      results();
   end

   // Test sequence
   initial
   begin
      repeat (2) @(posedge clock_in);
      #1;
      rst_b_in = 1'b1;
      rd_chk(5'h06, 16'h0064);
      rd_chk(5'h07, 16'h2001);
      rd_chk(5'h08, 16'h2001);
      rd_chk(5'h09, 16'h0300);
      rd_chk(5'h1f, 16'h0000);
      $display("Test reset values done");
      wr_reg(5'h07, 16'hffff);
      rd_chk(5'h07, 16'hb7ff);
      `CHK(tx_view, 14'h3fff)
      wr_reg(5'h07, 16'h0000);
      rd_chk(5'h07, 16'h0000);
      wr_reg(5'h06, 16'hffff);
      rd_chk(5'h06, 16'h0064);
      wr_reg(5'h08, 16'hffff);
      rd_chk(5'h08, 16'h2001);
      for (int m = 0; m < 8; m++)
      begin
         w = {m[2:0], m[2:0], m[0], m[1], m[2], 7'h7f};
         wr_reg(5'h09, w);
         rd_chk(5'h09, w & 16'hff80);
         `CHK(cfg_view, w[15:8])
      end
      $display("Test register writes done");
      eng_u.set_status(1'b1, 1'b1, 1'b0, 1'b1);
      rd_chk(5'h06, 16'h006d);
      eng_u.set_status(1'b0, 1'b0, 1'b0, 1'b1);
      eng_u.pulse(2'h0, 16'h0000);
      rd_chk(5'h06, 16'h0074);
      rd_chk(5'h06, 16'h0064);
      eng_u.pulse(2'h1, 16'h0000);
      rd_chk(5'h06, 16'h0066);
      rd_chk(5'h06, 16'h0064);
      // Page arrives in the same cycle as a clearing read
      reg_addr_in = 5'h06;
      reg_rd_in = 1'b1;
      eng_u.pulse(2'h1, 16'h0000);
      reg_rd_in = 1'b0;
      @(posedge clock_in);
      #1;
      rd_chk(5'h06, 16'h0066);
      rd_chk(5'h06, 16'h0064);
      $display("Test latched status done");
      eng_u.set_status(1'b0, 1'b0, 1'b1, 1'b1);
      eng_u.pulse(2'h1, 16'hd5aa);
      rd_chk(5'h08, 16'hddaa);
      eng_u.pulse(2'h1, 16'h1234);
      rd_chk(5'h08, 16'h1234);
      eng_u.pulse(2'h2, 16'h0000);
      rd_chk(5'h07, 16'h0800);
      `CHK(tx_page_parity_out, 1'b1)
      eng_u.pulse(2'h2, 16'h0000);
      rd_chk(5'h07, 16'h0000);
      $display("Test page exchange done");
      eng_u.set_status(1'b0, 1'b0, 1'b1, 1'b0);
      watch_diag();
      `CHK(hit, 1'b1)
      eng_u.set_status(1'b0, 1'b0, 1'b1, 1'b1);
      wr_reg(5'h09, 16'h0300);
      watch_diag();
      eng_u.set_status(1'b0, 1'b0, 1'b1, 1'b0);
      watch_diag();
      `CHK(hit, 1'b0)
      $display("Test cable diagnostic done");
      // Advertisement change, then a negotiation restart reseeds both parities
      own_base_parity_in = 1'b0;
      partner_base_parity_in = 1'b0;
      wr_reg(5'h09, 16'h0200);
      eng_u.set_status(1'b0, 1'b0, 1'b0, 1'b1);
      rd_chk(5'h06, 16'h0066);
      rd_chk(5'h07, 16'h0800);
      rd_chk(5'h08, 16'h1a34);
      // Second reset in mid-run with the full-duplex strap low
      strap_adv_gig_full_in = 1'b0;
      rst_b_in = 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
      rst_b_in = 1'b1;
      rd_chk(5'h06, 16'h0064);
      rd_chk(5'h07, 16'h2801);
      rd_chk(5'h08, 16'h2801);
      rd_chk(5'h09, 16'h0100);
      `CHK({adv_gig_full_out, adv_gig_half_out}, 2'h1)
      $display("Test restart and strap done");
      results();
   end
endmodule : angr_regs_tb_top

bind angr_regs angr_monitor mon_u
(
   .clock_in, .rst_b_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
   .reg_rdata_out, .parallel_detect_fault_in, .page_received_in, .page_sent_in,
   .base_page_done_in, .link_up_in, .tx_more_pages_out, .tx_page_parity_out,
   .tx_page_code_out, .test_mode_out, .adv_gig_full_out, .cable_diag_start_out
);
